//--- hdl/test_status_word.sv
// Built-in test status word register with AHB-Lite slave and mode command hooks
`timescale 1ns/1ps
`include "test_word_regs.svh"

module test_status_word
  import test_word_pkg::*;
#(
  parameter int DATA_W = 32
) (
  input wire logic hclk,                    // 25 MHz bus clock
  input wire logic hresetn,                 // Master reset, active low
  input wire logic hsel,                    // Slave select
  input wire logic [31:0] haddr,            // Byte address
  input wire logic [1:0] htrans,            // Transfer type
  input wire logic hwrite,                  // Write when high
  input wire logic [2:0] hsize,             // Transfer size
  input wire logic [DATA_W-1:0] hwdata,     // Write data
  input wire logic hready,                  // Bus ready
  output logic hreadyout,                   // Slave ready
  output logic [DATA_W-1:0] hrdata,         // Read data
  output logic hresp,                       // Always OKAY
  input wire logic tx_a_inhibit_pin,        // Bus A transmit inhibit
  input wire logic tx_b_inhibit_pin,        // Bus B transmit inhibit
  input wire logic autoinit_enable_pin,     // Auto-initialization enable
  input wire logic [5:0] rt_addr_pins,      // Terminal address and parity pins
  input wire logic shutdown_rx_too,         // Shutdown also disables receiver
  input wire logic [15:0] alt_test_word,    // Host maintained alternate word
  input wire mode_cmd_type mode_cmd,        // Fulfilled mode command
  input wire test_result_type test_result,  // Self-test and load results
  output word_out_type mode_reply,          // Mode data word for response
  output word_out_type buffer_write,        // Copy into mode data buffer
  output logic [15:0] test_word,            // Current test status word
  output logic [1:0] init_fail_kind         // Operational status failure type
);

  // Refuse widths the slave cannot serve
  if (DATA_W != 32) begin : g_width_check
    $error("test_status_word: DATA_W must be 32");
  end

  // Timing overview of the block
  // Bus: address edge, then one wait state, then the data phase ends.
  // The wait state costs a cycle per access but keeps hrdata on a flop.
  // Write data is taken at the wait-state edge, when hwdata stands.
  // Reads of unmapped words return zero, writes to them are dropped.
  // The response is always OKAY; no error path is built.
  // Mode commands: one pulse per fulfilled command, from the engine.
  // Reply word leaves one cycle after the command pulse.
  // The buffer copy follows one cycle after the reply.
  // Hazard: none; a new transmit-word command does not disturb a pending copy.
  // The engine never issues two such commands back to back.
  // Events: each result pulse sets its bit on the next edge, a load failure only when enabled and first after reset.
  // A device event in the same cycle as a host write wins.
  // A device event in the same cycle as a soft reset wins as well.
  // Limitation: loopback and RAM test engines live outside this block.
  // Limitation: the alternate word is kept by the host elsewhere.

  // Bus state
  bus_phase_type phase_q;
  logic [`TW_ADDR_W-1:0] addr_q;
  logic wr_q;
  logic hreadyout_q;
  logic [DATA_W-1:0] hrdata_q;
  logic hresp_q;

  // Test status word state and next value
  logic [15:0] bit_q;
  logic [15:0] bit_d;
  logic [DATA_W-1:0] ctrl_q;

  // Operational status address field and failure type
  logic [5:0] opaddr_q;
  logic [5:0] opaddr_d;
  logic [1:0] fail_kind_q;
  logic [1:0] fail_kind_d;

  // Post-reset sequencing
  logic mr_load_q;
  logic init_window_q;

  // Reply path and buffer copy
  word_out_type reply_q;
  word_out_type buf_q;
  logic [15:0] pending_q;
  logic pending_valid_q;

  // Odd parity over five address bits and the parity bit
  // Used for both the pin value and the loaded value
  function automatic logic parity_bad(input logic [5:0] a);
    parity_bad = ~(^a);
  endfunction

  // Register index match on the word address
  // Low two address bits are ignored: only whole words are served
  function automatic logic at_reg(input logic [`TW_ADDR_W-1:0] a,
                                  input logic [`TW_ADDR_W-1:0] ofs);
    at_reg = (a[`TW_ADDR_W-1:2] == ofs[`TW_ADDR_W-1:2]);
  endfunction

  // Address phase decode
  wire logic take_req = hsel & htrans[1] & hready;
  wire logic in_data = (phase_q == ph_data);
  wire logic wr_bit = in_data & wr_q & at_reg(addr_q, `TW_BIT_WORD_OFS);
  wire logic wr_ctrl = in_data & wr_q & at_reg(addr_q, `TW_CTRL_OFS);
  wire logic rd_bit = at_reg(addr_q, `TW_BIT_WORD_OFS);
  wire logic rd_ctrl = at_reg(addr_q, `TW_CTRL_OFS);
  wire logic rd_opstat = at_reg(addr_q, `TW_OPSTAT_OFS);

  // Soft reset is a write-one strobe, never stored
  wire logic soft_rst = wr_ctrl & hwdata[`TW_CTRL_SOFT_RST];
  wire logic alt_sel = ctrl_q[`TW_CTRL_ALT_SEL];

  // Mode command decode
  wire logic mc_go = mode_cmd.valid;
  wire logic [4:0] mc = mode_cmd.code;
  wire logic mc_shut = mc_go & ((mc == `TW_MC_TX_SHUTDOWN) |
                                ((mc == `TW_MC_SEL_TX_SHUTDOWN) & mode_cmd.sel_match));
  wire logic mc_unshut = mc_go & ((mc == `TW_MC_OVR_TX_SHUTDOWN) |
                                  ((mc == `TW_MC_OVR_SEL_TX_SHUTDOWN) & mode_cmd.sel_match));
  // Shutdown only ever hits the inactive bus
  wire logic shut_a = mc_shut & mode_cmd.on_bus_b;
  wire logic shut_b = mc_shut & ~mode_cmd.on_bus_b;
  wire logic unshut_a = mc_unshut & mode_cmd.on_bus_b;
  wire logic unshut_b = mc_unshut & ~mode_cmd.on_bus_b;
  wire logic tf_inh = mc_go & (mc == `TW_MC_INH_TFLAG);
  wire logic tf_ovr = mc_go & (mc == `TW_MC_OVR_INH_TFLAG);
  wire logic tx_word_cmd = mc_go & (mc == `TW_MC_TX_BIT_WORD);

  // Auto-initialization result
  // Only the first load after master reset counts; later pulses are ignored
  wire logic init_done = test_result.init_done & init_window_q;
  wire logic init_fail = init_done & test_result.init_fail & autoinit_enable_pin;

  // Read data selection
  // Upper half of every word reads zero
  wire logic [DATA_W-1:0] rd_word =
    rd_bit ? {16'h0000, bit_q} :
    rd_ctrl ? ctrl_q :
    rd_opstat ? {16'h0000, opaddr_q, 8'h00, fail_kind_q} :
    32'h0000_0000;

  // Bus phase sequencer: one wait state so read data leaves a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= ph_idle;
      addr_q <= 12'h000;
      wr_q <= 1'b0;
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
      hresp_q <= 1'b0;
    end else begin
      case (phase_q)
        ph_idle: begin
          if (take_req) begin
            phase_q <= ph_data;
            addr_q <= haddr[`TW_ADDR_W-1:0];
            wr_q <= hwrite;
            hreadyout_q <= 1'b0;
          end
        end
        ph_data: begin
          phase_q <= ph_idle;
          hreadyout_q <= 1'b1;
          hrdata_q <= wr_q ? 32'h0000_0000 : rd_word;
        end
        default: begin
          phase_q <= ph_idle;
          hreadyout_q <= 1'b1;
        end
      endcase
    end
  end

  // Control register: only the alternate-select bit is stored
  // Soft reset bit is a strobe and always reads back zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `TW_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= {31'h0000_0000, hwdata[`TW_CTRL_ALT_SEL]};
    end
  end

  // Next value of the test status word; device events are applied last so they win
  always_comb begin
    bit_d = bit_q;
    if (wr_bit) begin
      bit_d[`TW_WR_HI:`TW_WR_LO] = hwdata[`TW_WR_HI:`TW_WR_LO];
    end
    if (soft_rst | mr_load_q) begin
      bit_d[`TW_TX_A_SD] = tx_a_inhibit_pin;
      bit_d[`TW_TX_B_SD] = tx_b_inhibit_pin;
      bit_d[`TW_RX_A_SD] = 1'b0;
      bit_d[`TW_RX_B_SD] = 1'b0;
      bit_d[`TW_LB_FAIL_A] = 1'b0;
      bit_d[`TW_LB_FAIL_B] = 1'b0;
      bit_d[`TW_TF_INH] = 1'b0;
    end
    // Override of a shutdown releases the bus
    if (unshut_a) begin
      bit_d[`TW_TX_A_SD] = tx_a_inhibit_pin;
      bit_d[`TW_RX_A_SD] = 1'b0;
    end
    if (unshut_b) begin
      bit_d[`TW_TX_B_SD] = tx_b_inhibit_pin;
      bit_d[`TW_RX_B_SD] = 1'b0;
    end
    if (tx_a_inhibit_pin | shut_a) begin
      bit_d[`TW_TX_A_SD] = 1'b1;
    end
    if (tx_b_inhibit_pin | shut_b) begin
      bit_d[`TW_TX_B_SD] = 1'b1;
    end
    if (shut_a & shutdown_rx_too) begin
      bit_d[`TW_RX_A_SD] = 1'b1;
    end
    if (shut_b & shutdown_rx_too) begin
      bit_d[`TW_RX_B_SD] = 1'b1;
    end
    if (test_result.lb_fail_a) begin
      bit_d[`TW_LB_FAIL_A] = 1'b1;
    end
    if (test_result.lb_fail_b) begin
      bit_d[`TW_LB_FAIL_B] = 1'b1;
    end
    if (test_result.ram_fail) begin
      bit_d[`TW_RAM_FAIL] = 1'b1;
    end
    bit_d[`TW_ADDR_PAR] = parity_bad(opaddr_d);
    if (init_fail) begin
      bit_d[`TW_AUTOINIT_FAIL] = 1'b1;
    end
    if (tf_ovr) begin
      bit_d[`TW_TF_INH] = 1'b0;
    end
    if (tf_inh) begin
      bit_d[`TW_TF_INH] = 1'b1;
    end
  end

  // Next value of the operational status address field and failure type
  // Failure type is sticky until master reset
  always_comb begin
    opaddr_d = opaddr_q;
    fail_kind_d = fail_kind_q;
    if (mr_load_q) begin
      opaddr_d = rt_addr_pins;
    end else if (init_done & ~test_result.init_fail) begin
      opaddr_d = test_result.init_addr;
    end
    if (init_fail) begin
      fail_kind_d = fail_kind_q | test_result.fail_kind;
    end
  end

  // Test status word and operational status storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_q <= `TW_BIT_WORD_RST;
      opaddr_q <= `TW_OPSTAT_ADDR_RST;
      fail_kind_q <= 2'b00;
    end else begin
      bit_q <= bit_d;
      opaddr_q <= opaddr_d;
      fail_kind_q <= fail_kind_d;
    end
  end

  // Pin levels are caught on the first edge after reset release, never in reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mr_load_q <= 1'b1;
      init_window_q <= 1'b1;
    end else begin
      mr_load_q <= 1'b0;
      // Only the first load after master reset can report failure
      if (init_done) begin
        init_window_q <= 1'b0;
      end
    end
  end

  // Mode data word reply, then copy into the data buffer one cycle later
  // The copy waits a cycle so the response path sees the word first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reply_q <= '0;
      buf_q <= '0;
      pending_q <= 16'h0000;
      pending_valid_q <= 1'b0;
    end else begin
      reply_q.valid <= tx_word_cmd;
      if (tx_word_cmd) begin
        reply_q.data <= alt_sel ? alt_test_word : bit_q;
        pending_q <= alt_sel ? alt_test_word : bit_q;
      end
      pending_valid_q <= tx_word_cmd;
      buf_q.valid <= pending_valid_q;
      if (pending_valid_q) begin
        buf_q.data <= pending_q;
      end
    end
  end

  // Outputs straight from flops
  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = hresp_q;
  assign mode_reply = reply_q;
  assign buffer_write = buf_q;
  assign test_word = bit_q;
  assign init_fail_kind = fail_kind_q;

endmodule

//--- hdl/test_word_regs.svh
// Offsets, field positions, reset values and codes of the test status word block
`ifndef TEST_WORD_REGS_SVH
`define TEST_WORD_REGS_SVH

// Register word indices; the byte address is four times the index
`define TW_ADDR_W 12
`define TW_BIT_WORD_IDX 12'h014
`define TW_OPSTAT_IDX 12'h002
`define TW_CTRL_IDX 12'h008

// Register byte addresses on the bus
`define TW_BIT_WORD_OFS 12'h050
`define TW_CTRL_OFS 12'h020
`define TW_OPSTAT_OFS 12'h008

// Test status word field positions
`define TW_TX_A_SD 15
`define TW_TX_B_SD 14
`define TW_RX_A_SD 13
`define TW_RX_B_SD 12
`define TW_USER_HI 11
`define TW_USER_LO 6
`define TW_LB_FAIL_A 5
`define TW_LB_FAIL_B 4
`define TW_RAM_FAIL 3
`define TW_ADDR_PAR 2
`define TW_AUTOINIT_FAIL 1
`define TW_TF_INH 0

// Host writable window of the test status word
`define TW_WR_HI 11
`define TW_WR_LO 4

// Control register fields
`define TW_CTRL_ALT_SEL 0
`define TW_CTRL_SOFT_RST 1

// Reset values
`define TW_BIT_WORD_RST 16'h0000
`define TW_CTRL_RST 32'h0000_0000
`define TW_OPSTAT_ADDR_RST 6'h00

// Mode command codes
`define TW_MC_TX_SHUTDOWN 5'h04
`define TW_MC_OVR_TX_SHUTDOWN 5'h05
`define TW_MC_INH_TFLAG 5'h06
`define TW_MC_OVR_INH_TFLAG 5'h07
`define TW_MC_TX_BIT_WORD 5'h13
`define TW_MC_SEL_TX_SHUTDOWN 5'h14
`define TW_MC_OVR_SEL_TX_SHUTDOWN 5'h15

`endif

//--- hdl/test_word_pkg.sv
// Types shared by the test status word block
package test_word_pkg;

  // Bus phase of the register slave
  typedef enum logic [0:0] {
    ph_idle,
    ph_data
  } bus_phase_type;

  // Mode command fulfilled by the protocol engine
  typedef struct packed {
    logic valid;      // One-cycle pulse
    logic [4:0] code; // Mode code
    logic on_bus_b;   // Command arrived on bus B
    logic sel_match;  // Data word matched the bus select register
  } mode_cmd_type;

  // Self-test and auto-initialization results
  typedef struct packed {
    logic lb_fail_a;       // Pulse: loopback failure, bus A
    logic lb_fail_b;       // Pulse: loopback failure, bus B
    logic ram_fail;        // Pulse: RAM self-test failure
    logic init_done;       // Pulse: auto-initialization finished
    logic init_fail;       // With init_done: load failed
    logic [1:0] fail_kind; // With init_done: failure type
    logic [5:0] init_addr; // With init_done: loaded address and parity
  } test_result_type;

  // Word handed to the response path or the data buffer
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } word_out_type;

endpackage

//--- tb/test_word_checker.sv
// Port checks for the test status word block
`timescale 1ns/1ps
module test_word_checker
  import test_word_pkg::*;
(
  input wire logic hclk, // Bus clock
  input wire logic hresetn, // Master reset
  input wire logic hsel, // Select
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hready, // Bus ready
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic tx_a_inhibit_pin, // Pin A
  input wire logic tx_b_inhibit_pin, // Pin B
  input wire logic [15:0] alt_test_word, // Alternate word
  input wire mode_cmd_type mode_cmd, // Mode command
  input wire test_result_type test_result, // Test results
  input wire word_out_type mode_reply, // Reply word
  input wire word_out_type buffer_write, // Buffer copy
  input wire logic [15:0] test_word // Status word
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Decoded command of interest
  wire take_19 = mode_cmd.valid && mode_cmd.code == 5'h13;
  wire take_req = hsel && htrans[1] && hready && hreadyout;

  // Bus handshake: exactly one wait state, always OKAY
  a_wait_state: assert property (take_req |=> !hreadyout ##1 hreadyout)
    else $error("data phase length wrong");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not OKAY");
  // Reply then buffer copy, with the right word
  a_reply_time: assert property (take_19 |=> mode_reply.valid ##1 buffer_write.valid)
    else $error("reply or buffer copy late");
  a_reply_cause: assert property (mode_reply.valid |-> $past(take_19))
    else $error("reply without command");
  a_reply_data: assert property (mode_reply.valid |-> mode_reply.data == $past(test_word)
    || mode_reply.data == $past(alt_test_word))
    else $error("reply word wrong");
  a_buffer_copy: assert property (buffer_write.valid |-> buffer_write.data == $past(mode_reply.data))
    else $error("buffer copy differs");
  // Event driven bits
  a_pin_a_sd: assert property (tx_a_inhibit_pin |=> test_word[15])
    else $error("bus A shutdown bit low");
  a_pin_b_sd: assert property (tx_b_inhibit_pin |=> test_word[14])
    else $error("bus B shutdown bit low");
  a_tflag_set: assert property (mode_cmd.valid && mode_cmd.code == 5'h06 |=> test_word[0])
    else $error("flag inhibit bit not set");
  a_tflag_clr: assert property (mode_cmd.valid && mode_cmd.code == 5'h07 |=> !test_word[0])
    else $error("flag inhibit bit not cleared");
  a_lb_fail: assert property (test_result.lb_fail_a |=> test_word[5])
    else $error("loopback A bit not set");
  a_ram_rise: assert property ($rose(test_word[3]) |-> $past(test_result.ram_fail))
    else $error("RAM fail bit rose alone");
  // User bits move only around a bus data phase
  a_user_quiet: assert property (!$stable(test_word[11:6]) |->
    !$past(hreadyout) || !$past(hreadyout, 2))
    else $error("user bits changed without write");
  c_reply: cover property (take_19 ##1 mode_reply.valid);
  c_load_fail: cover property ($rose(test_word[1]));
  c_bus: cover property (take_req);
endmodule

bind test_status_word test_word_checker i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .tx_a_inhibit_pin(tx_a_inhibit_pin), .tx_b_inhibit_pin(tx_b_inhibit_pin),
  .alt_test_word(alt_test_word), .mode_cmd(mode_cmd), .test_result(test_result),
  .mode_reply(mode_reply), .buffer_write(buffer_write), .test_word(test_word));

//--- tb/ahb_host.sv
// Host side bus master model for the register slave
`timescale 1ns/1ps
module ahb_host (
  input wire logic hclk, // Bus clock
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  output logic hsel, // Select
  output logic [31:0] haddr, // Address
  output logic [1:0] htrans, // Transfer type
  output logic hwrite, // Direction
  output logic [2:0] hsize, // Always word
  output logic [31:0] hwdata // Write data
);
  // Idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Single word transfer; no cycle count assumed, bench timeout cuts a hang
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h00000, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    // Released data bus shows a changed pattern, not stale data
    hwdata <= ~wd;
  endtask
endmodule

//--- tb/built_in_test_status_word_bench.sv
// Self-checking bench for the test status word block
`timescale 1ns/1ps
`include "test_word_regs.svh"
module built_in_test_status_word_bench;
  import test_word_pkg::*;
  typedef struct packed {
    logic mv;
    logic [4:0] code;
    logic bus_b;
    logic sel;
    logic [3:0] ev; // lb_a, lb_b, ram, init fail
    logic [15:0] exp;
  } row_type;
  localparam row_type ROWS [12] = '{
    '{1, 5'h04, 1, 0, 4'h0, 16'ha000}, '{1, 5'h05, 1, 0, 4'h0, 16'h0000},
    '{1, 5'h14, 0, 1, 4'h0, 16'h5000}, '{1, 5'h15, 0, 1, 4'h0, 16'h0000},
    '{1, 5'h14, 0, 0, 4'h0, 16'h0000}, '{1, 5'h06, 0, 0, 4'h0, 16'h0001},
    '{1, 5'h07, 0, 0, 4'h0, 16'h0000}, '{0, 5'h00, 0, 0, 4'h8, 16'h0020},
    '{0, 5'h00, 0, 0, 4'h4, 16'h0030}, '{0, 5'h00, 0, 0, 4'h2, 16'h0038},
    '{0, 5'h00, 0, 0, 4'h1, 16'h003a}, '{1, 5'h06, 0, 0, 4'h0, 16'h003b}};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_a_inhibit_pin, tx_b_inhibit_pin;
  logic autoinit_enable_pin, shutdown_rx_too;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, init_fail_kind;
  logic [2:0] hsize;
  logic [5:0] rt_addr_pins;
  logic [15:0] alt_test_word, test_word;
  mode_cmd_type mode_cmd;
  test_result_type test_result;
  word_out_type mode_reply, buffer_write;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;

  test_status_word i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .tx_a_inhibit_pin(tx_a_inhibit_pin),
    .tx_b_inhibit_pin(tx_b_inhibit_pin), .autoinit_enable_pin(autoinit_enable_pin),
    .rt_addr_pins(rt_addr_pins), .shutdown_rx_too(shutdown_rx_too),
    .alt_test_word(alt_test_word), .mode_cmd(mode_cmd), .test_result(test_result),
    .mode_reply(mode_reply), .buffer_write(buffer_write), .test_word(test_word),
    .init_fail_kind(init_fail_kind));
  ahb_host i_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // 25 MHz clock
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // Cycle ceiling well above the planned run
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      end_sim;
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, rd);
    i_host.xfer(1'b0, `TW_BIT_WORD_OFS, 32'h0, rd);
  endtask
  // Transmit test word command; reply then buffer copy one cycle apart
  task automatic mc19(input logic [16:0] e);
    @(posedge hclk);
    mode_cmd <= '{1'b1, 5'h13, 1'b0, 1'b0};
    @(posedge hclk);
    mode_cmd <= '0;
    #1 chk("reply", {15'h0, e}, {mode_reply.valid, mode_reply.data});
    @(posedge hclk);
    #1 chk("buffer", {15'h0, e}, {buffer_write.valid, buffer_write.data});
  endtask
  task end_sim;
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence: table of events, then bus, reply and reset cases
  initial begin
    hresetn = 1'b0;
    tx_a_inhibit_pin = 1'b0;
    tx_b_inhibit_pin = 1'b0;
    autoinit_enable_pin = 1'b1;
    shutdown_rx_too = 1'b1;
    rt_addr_pins = 6'h01;
    alt_test_word = 16'h1234;
    mode_cmd = '0;
    test_result = '0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    #1 chk("reset word", 32'h0, test_word);
    foreach (ROWS[i]) begin
      @(posedge hclk);
      mode_cmd <= '{ROWS[i].mv, ROWS[i].code, ROWS[i].bus_b, ROWS[i].sel};
      test_result <= '{ROWS[i].ev[3], ROWS[i].ev[2], ROWS[i].ev[1], ROWS[i].ev[0],
        ROWS[i].ev[0], 2'b01, 6'h00};
      @(posedge hclk);
      mode_cmd <= '0;
      test_result <= '0;
      @(posedge hclk);
      #1 chk("event word", ROWS[i].exp, test_word);
    end
    chk("fail kind", 32'h1, init_fail_kind);
    wr_rd(`TW_BIT_WORD_OFS, 32'hffff_ffff);
    chk("write ones", 32'h0ffb, rd);
    wr_rd(`TW_BIT_WORD_OFS, 32'h0);
    chk("write zeros", 32'h000b, rd);
    mc19({1'b1, 16'h000b});
    i_host.xfer(1'b1, `TW_CTRL_OFS, 32'h1, rd);
    mc19({1'b1, 16'h1234});
    @(posedge hclk);
    tx_a_inhibit_pin <= 1'b1;
    wr_rd(`TW_BIT_WORD_OFS, 32'h0ab0);
    chk("pin and user", 32'h8abb, rd);
    wr_rd(`TW_CTRL_OFS, 32'h2);
    chk("soft reset", 32'h8a8a, rd);
    i_host.xfer(1'b0, 12'h100, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    // Second master reset with bad address parity and bus B inhibited
    @(posedge hclk);
    hresetn <= 1'b0;
    rt_addr_pins <= 6'h00;
    tx_a_inhibit_pin <= 1'b0;
    tx_b_inhibit_pin <= 1'b1;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    #1 chk("master reset", 32'h4004, test_word);
    chk("kind cleared", 32'h0, init_fail_kind);
    // Good load replaces the pin address and clears the parity error
    @(posedge hclk);
    test_result <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 2'b00, 6'h02};
    @(posedge hclk);
    test_result <= '0;
    i_host.xfer(1'b0, `TW_OPSTAT_OFS, 32'h0, rd);
    chk("loaded address", 32'h0800, rd);
    chk("parity cleared", 32'h4000, test_word);
    // A later load failure is outside the post-reset window
    @(posedge hclk);
    test_result <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 2'b10, 6'h00};
    @(posedge hclk);
    test_result <= '0;
    @(posedge hclk);
    #1 chk("late load word", 32'h4000, test_word);
    chk("late load kind", 32'h0, init_fail_kind);
    end_sim;
  end
endmodule
